//--- logic/mdc_pkg.sv
package mdc_pkg;
  localparam int MDC_DATA_W = 32;
  localparam int MDC_ADDR_W = 32;
  localparam int MDC_MASTERS = 2;
  localparam int MDC_HS_NUM = 11;
  localparam int MDC_HS_SEL_W = 4;
  localparam int MDC_LEN_W = 12;
  localparam int MDC_FIFO_DEPTH = 2;
  localparam int MDC_LVL_W = 2;
  localparam logic [MDC_LVL_W-1:0] MDC_FIFO_FULL = 2'h2;
  localparam logic [MDC_LVL_W-1:0] MDC_FIFO_HALF = 2'h1;
  localparam logic [MDC_LEN_W-1:0] MDC_BURST_LEN = 12'h004;
  localparam logic [MDC_LEN_W-1:0] MDC_SINGLE_LEN = 12'h001;
  localparam logic [MDC_ADDR_W-1:0] MDC_WORD_BYTES = 32'h0000_0004;

  typedef enum logic [1:0] {MDC_HS_HW, MDC_HS_SW, MDC_HS_IRQ} mdc_hs_mode_type;
  typedef enum logic {MDC_SIDE_IDLE, MDC_SIDE_RUN} mdc_side_state_type;

  function automatic logic [MDC_ADDR_W-1:0] mdc_next_addr(input logic [MDC_ADDR_W-1:0] addr, input logic inc);
    mdc_next_addr = inc ? addr + MDC_WORD_BYTES : addr;
  endfunction : mdc_next_addr

  function automatic logic [MDC_LEN_W-1:0] mdc_txn_len(input logic is_mem, input logic single,
                                                       input logic [MDC_LEN_W-1:0] left);
    if (is_mem) begin
      mdc_txn_len = left;
    end else if (single) begin
      mdc_txn_len = MDC_SINGLE_LEN;
    end else begin
      mdc_txn_len = (left < MDC_BURST_LEN) ? left : MDC_BURST_LEN;
    end
  endfunction : mdc_txn_len
endpackage : mdc_pkg

//--- logic/mdc_fifo_if.sv
interface mdc_fifo_if import mdc_pkg::*; ();
  logic push_valid;
  logic push_ready;
  logic [MDC_DATA_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [MDC_DATA_W-1:0] pop_data;
  logic [MDC_LVL_W-1:0] level;

  modport buf_mp (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, level);
  modport ctl_mp (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data, level);
endinterface : mdc_fifo_if

//--- logic/mdc_buf.sv
module mdc_buf import mdc_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  mdc_fifo_if.buf_mp f
);
  logic [MDC_DATA_W-1:0] mem_ff [MDC_FIFO_DEPTH];
  logic wr_idx_ff;
  logic rd_idx_ff;
  logic [MDC_LVL_W-1:0] cnt_ff;
  wire do_push;
  wire do_pop;

  assign f.push_ready = (cnt_ff != MDC_FIFO_FULL);
  assign f.pop_valid = (cnt_ff != '0);
  assign f.pop_data = mem_ff[rd_idx_ff];
  assign f.level = cnt_ff;
  assign do_push = f.push_valid & f.push_ready;
  assign do_pop = f.pop_ready & f.pop_valid;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_idx_ff <= 1'b0;
      rd_idx_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      wr_idx_ff <= wr_idx_ff ^ do_push;
      rd_idx_ff <= rd_idx_ff ^ do_pop;
      cnt_ff <= cnt_ff + MDC_LVL_W'(do_push) - MDC_LVL_W'(do_pop);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem_ff[wr_idx_ff] <= f.push_data;
    end
  end
endmodule : mdc_buf

//--- logic/mdc_hs.sv
module mdc_hs import mdc_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic is_mem_i,
  input mdc_hs_mode_type mode_i,
  input wire logic [MDC_HS_SEL_W-1:0] sel_i,
  input wire logic [MDC_HS_NUM-1:0] hs_req_i,
  input wire logic [MDC_HS_NUM-1:0] hs_single_i,
  input wire logic sw_req_i,
  input wire logic sw_single_i,
  input wire logic txn_done_i,
  output logic txn_go_o,
  output logic txn_single_o,
  output logic [MDC_HS_NUM-1:0] hs_ack_o
);
  logic sw_pend_ff;
  logic sw_single_ff;
  logic [MDC_HS_NUM-1:0] ack_ff;
  wire sel_ok;
  wire pin_req;
  wire pin_single;
  wire ack_now;

  assign sel_ok = (sel_i < MDC_HS_SEL_W'(MDC_HS_NUM));
  assign pin_req = sel_ok & hs_req_i[sel_i];
  assign pin_single = sel_ok & hs_single_i[sel_i];
  // R7 memory needs no request
  // R13 interrupt mode uses only the request line
  // hold off one cycle while acking: the old request may still be high
  assign txn_go_o = is_mem_i | ((ack_ff == '0) &
                    ((mode_i == MDC_HS_SW) ? sw_pend_ff : pin_req));
  assign txn_single_o = ~is_mem_i & ((mode_i == MDC_HS_IRQ) | ((mode_i == MDC_HS_SW) ? sw_single_ff : pin_single));
  assign ack_now = txn_done_i & ~is_mem_i & (mode_i != MDC_HS_SW) & sel_ok;
  assign hs_ack_o = ack_ff;

  // R12 software request latch, set wins
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_pend_ff <= 1'b0;
      sw_single_ff <= 1'b0;
    end else begin
      sw_pend_ff <= sw_req_i | (sw_pend_ff & ~(txn_done_i & (mode_i == MDC_HS_SW)));
      sw_single_ff <= sw_req_i ? sw_single_i : sw_single_ff;
    end
  end

  // R11 one-cycle acknowledge on selected line
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_ff <= '0;
    end else begin
      ack_ff <= ack_now ? (MDC_HS_NUM'(1) << sel_i) : '0;
    end
  end
endmodule : mdc_hs

//--- logic/mdc_top.sv
// Notes on behaviour
// R1 - two bus master ports, read and write
// R2 - eleven hardware handshake request lines
// R3 - controller alone sizes and ends blocks
// R4 - channel data passes its private buffer
// R5 - each item: one read, one write
// R6 - configuration arrives on a separate port
// R7 - memory endpoints never wait for requests
// R8 - memory only when sixteen waits or fewer
// R9 - run-time handshake selection per endpoint
// R10 - hardware, software or interrupt request types
// R11 - peripheral requests, controller acknowledges transaction
// R12 - software request replaces pins
// R13 - interrupt mode ignores other handshake inputs
// R14 - source, destination on same or different ports
// R15 - block ends when programmed length moved
// R16 - single interrupt output reports completion
// R17 - software stops activity before sleep
// R18 - single transaction moves exactly one item
// R19 - buffer mode gates by half fill
// R20 - port regranted only after transfer completes
// R21 - channel disabled and ports idle after reset
module mdc_top import mdc_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ch_start_i,
  input wire logic [MDC_LEN_W-1:0] block_len_i,
  input wire logic [MDC_ADDR_W-1:0] src_addr_i,
  input wire logic [MDC_ADDR_W-1:0] dst_addr_i,
  input wire logic src_inc_i,
  input wire logic dst_inc_i,
  input wire logic src_layer_i,
  input wire logic dst_layer_i,
  input wire logic fifo_mode_i,
  input wire logic src_is_mem_i,
  input wire logic dst_is_mem_i,
  input mdc_hs_mode_type src_mode_i,
  input mdc_hs_mode_type dst_mode_i,
  input wire logic [MDC_HS_SEL_W-1:0] src_sel_i,
  input wire logic [MDC_HS_SEL_W-1:0] dst_sel_i,
  input wire logic sw_src_req_i,
  input wire logic sw_src_single_i,
  input wire logic sw_dst_req_i,
  input wire logic sw_dst_single_i,
  input wire logic [MDC_HS_NUM-1:0] hs_req_i,
  input wire logic [MDC_HS_NUM-1:0] hs_single_i,
  input wire logic irq_clear_i,
  input wire logic [MDC_MASTERS-1:0] m_done_i,
  input wire logic [MDC_MASTERS-1:0][MDC_DATA_W-1:0] m_rdata_i,
  output logic [MDC_MASTERS-1:0] m_req_o,
  output logic [MDC_MASTERS-1:0] m_we_o,
  output logic [MDC_MASTERS-1:0][MDC_ADDR_W-1:0] m_addr_o,
  output logic [MDC_MASTERS-1:0][MDC_DATA_W-1:0] m_wdata_o,
  output logic [MDC_HS_NUM-1:0] src_ack_o,
  output logic [MDC_HS_NUM-1:0] dst_ack_o,
  output logic ch_active_o,
  output logic irq_o
);
  mdc_side_state_type rd_state_ff;
  mdc_side_state_type wr_state_ff;
  logic ch_on_ff;
  logic irq_ff;
  logic rd_busy_ff;
  logic wr_busy_ff;
  logic [MDC_LEN_W-1:0] rd_left_ff;
  logic [MDC_LEN_W-1:0] wr_left_ff;
  logic [MDC_LEN_W-1:0] rd_txn_ff;
  logic [MDC_LEN_W-1:0] wr_txn_ff;
  logic [MDC_ADDR_W-1:0] src_addr_ff;
  logic [MDC_ADDR_W-1:0] dst_addr_ff;
  logic [MDC_MASTERS-1:0] m_busy_ff;
  logic [MDC_MASTERS-1:0] m_own_wr_ff;
  logic [MDC_MASTERS-1:0] m_we_ff;
  logic [MDC_MASTERS-1:0][MDC_ADDR_W-1:0] m_addr_ff;
  logic [MDC_MASTERS-1:0][MDC_DATA_W-1:0] m_wdata_ff;

  wire src_go;
  wire src_single;
  wire dst_go;
  wire dst_single;
  wire rd_space;
  wire wr_avail;
  wire rd_start;
  wire wr_start;
  wire rd_want;
  wire wr_want;
  wire rd_grant;
  wire wr_grant;
  wire rd_ret;
  wire wr_ret;
  wire rd_txn_end;
  wire wr_txn_end;
  wire blk_end;
  wire load;
  wire [MDC_MASTERS-1:0] m_fin;
  wire rd_idle;
  wire wr_idle;
  wire rd_run;
  wire wr_run;
  wire same_layer;
  wire rd_port_free;
  wire wr_port_free;
  wire [MDC_MASTERS-1:0] rd_on_port;
  wire [MDC_MASTERS-1:0] wr_on_port;
  wire nxt_ch_on;
  wire nxt_irq;
  wire nxt_rd_busy;
  wire nxt_wr_busy;
  wire [MDC_ADDR_W-1:0] nxt_src_addr;
  wire [MDC_ADDR_W-1:0] nxt_dst_addr;

  // R4 private channel buffer
  mdc_fifo_if fif();

  mdc_buf u_buf (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .f(fif.buf_mp)
  );

  // R2 eleven shared request lines
  // R9 per-side handshake binding
  // R10 three request types
  mdc_hs u_src_hs (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .is_mem_i(src_is_mem_i),
    .mode_i(src_mode_i),
    .sel_i(src_sel_i),
    .hs_req_i(hs_req_i),
    .hs_single_i(hs_single_i),
    .sw_req_i(sw_src_req_i),
    .sw_single_i(sw_src_single_i),
    .txn_done_i(rd_txn_end),
    .txn_go_o(src_go),
    .txn_single_o(src_single),
    .hs_ack_o(src_ack_o)
  );

  mdc_hs u_dst_hs (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .is_mem_i(dst_is_mem_i),
    .mode_i(dst_mode_i),
    .sel_i(dst_sel_i),
    .hs_req_i(hs_req_i),
    .hs_single_i(hs_single_i),
    .sw_req_i(sw_dst_req_i),
    .sw_single_i(sw_dst_single_i),
    .txn_done_i(wr_txn_end),
    .txn_go_o(dst_go),
    .txn_single_o(dst_single),
    .hs_ack_o(dst_ack_o)
  );

  // R19 half-fill gating in buffer mode
  assign rd_space = fifo_mode_i ? (fif.level < MDC_FIFO_HALF) : fif.push_ready;
  assign wr_avail = fifo_mode_i ? (fif.level >= MDC_FIFO_HALF) : fif.pop_valid;

  assign rd_idle = (rd_state_ff == MDC_SIDE_IDLE);
  assign wr_idle = (wr_state_ff == MDC_SIDE_IDLE);
  assign rd_run = (rd_state_ff == MDC_SIDE_RUN);
  assign wr_run = (wr_state_ff == MDC_SIDE_RUN);
  // R6 block length and start addresses taken at load; other settings are read live
  assign load = ch_start_i & ~ch_on_ff & (block_len_i != '0);
  assign rd_start = ch_on_ff & rd_idle & (rd_left_ff != '0) & src_go;
  assign wr_start = ch_on_ff & wr_idle & (wr_left_ff != '0) & dst_go;
  assign rd_want = rd_run & ~rd_busy_ff & (rd_txn_ff != '0) & rd_space;
  assign wr_want = wr_run & ~wr_busy_ff & (wr_txn_ff != '0) & wr_avail;

  // R20 no grant while the port is busy
  // R14 same port: write wins to drain the buffer
  assign same_layer = (src_layer_i == dst_layer_i);
  assign rd_port_free = ~m_busy_ff[src_layer_i];
  assign wr_port_free = ~m_busy_ff[dst_layer_i];
  assign wr_grant = wr_want & wr_port_free;
  assign rd_grant = rd_want & rd_port_free & ~(wr_grant & same_layer);
  assign wr_on_port = wr_grant ? (MDC_MASTERS'(1) << dst_layer_i) : '0;
  assign rd_on_port = rd_grant ? (MDC_MASTERS'(1) << src_layer_i) : '0;

  assign m_fin = m_done_i & m_busy_ff;
  assign rd_ret = |(m_fin & ~m_own_wr_ff);
  assign wr_ret = |(m_fin & m_own_wr_ff);

  // R5 read result enters buffer, write drains it
  assign fif.push_valid = rd_ret;
  assign fif.push_data = m_rdata_i[src_layer_i];
  assign fif.pop_ready = wr_grant;

  assign rd_txn_end = rd_run & (rd_txn_ff == '0) & ~rd_busy_ff;
  assign wr_txn_end = wr_run & (wr_txn_ff == '0) & ~wr_busy_ff;
  // R3 block end decided by the controller
  // R15 last write completes the block
  assign blk_end = wr_ret & (wr_left_ff == MDC_SINGLE_LEN);

  assign m_req_o = m_busy_ff;
  assign m_we_o = m_we_ff;
  assign m_addr_o = m_addr_ff;
  assign m_wdata_o = m_wdata_ff;
  assign ch_active_o = ch_on_ff;
  assign irq_o = irq_ff;

  assign nxt_ch_on = load | (ch_on_ff & ~blk_end);
  // R16 sticky, set wins
  assign nxt_irq = blk_end | (irq_ff & ~irq_clear_i);
  assign nxt_rd_busy = rd_grant | (rd_busy_ff & ~rd_ret);
  assign nxt_wr_busy = wr_grant | (wr_busy_ff & ~wr_ret);
  assign nxt_src_addr = load ? src_addr_i : (rd_grant ? mdc_next_addr(src_addr_ff, src_inc_i) : src_addr_ff);
  assign nxt_dst_addr = load ? dst_addr_i : (wr_grant ? mdc_next_addr(dst_addr_ff, dst_inc_i) : dst_addr_ff);

  // R21 idle and disabled out of reset
  // R16 completion interrupt, set wins over clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ch_on_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ch_on_ff <= nxt_ch_on;
      irq_ff <= nxt_irq;
    end
  end

  // R18 single transaction is one item
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_state_ff <= MDC_SIDE_IDLE;
      rd_txn_ff <= '0;
      rd_left_ff <= '0;
    end else begin
      if (rd_start) begin
        rd_state_ff <= MDC_SIDE_RUN;
        rd_txn_ff <= mdc_txn_len(src_is_mem_i, src_single, rd_left_ff);
      end else if (rd_txn_end) begin
        rd_state_ff <= MDC_SIDE_IDLE;
      end else if (rd_grant) begin
        rd_txn_ff <= rd_txn_ff - MDC_SINGLE_LEN;
      end
      if (load) begin
        rd_left_ff <= block_len_i;
      end else if (rd_grant) begin
        rd_left_ff <= rd_left_ff - MDC_SINGLE_LEN;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_state_ff <= MDC_SIDE_IDLE;
      wr_txn_ff <= '0;
      wr_left_ff <= '0;
    end else begin
      if (wr_start) begin
        wr_state_ff <= MDC_SIDE_RUN;
        wr_txn_ff <= mdc_txn_len(dst_is_mem_i, dst_single, wr_left_ff);
      end else if (wr_txn_end) begin
        wr_state_ff <= MDC_SIDE_IDLE;
      end else if (wr_grant) begin
        wr_txn_ff <= wr_txn_ff - MDC_SINGLE_LEN;
      end
      if (load) begin
        wr_left_ff <= block_len_i;
      end else if (wr_ret) begin
        wr_left_ff <= wr_left_ff - MDC_SINGLE_LEN;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_busy_ff <= 1'b0;
      wr_busy_ff <= 1'b0;
      src_addr_ff <= '0;
      dst_addr_ff <= '0;
    end else begin
      rd_busy_ff <= nxt_rd_busy;
      wr_busy_ff <= nxt_wr_busy;
      src_addr_ff <= nxt_src_addr;
      dst_addr_ff <= nxt_dst_addr;
    end
  end

  // R1 two master ports, each serving either side
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      m_busy_ff <= '0;
      m_own_wr_ff <= '0;
      m_we_ff <= '0;
      m_addr_ff <= '0;
      m_wdata_ff <= '0;
    end else begin
      for (int m = 0; m < MDC_MASTERS; m++) begin
        if (wr_on_port[m]) begin
          m_busy_ff[m] <= 1'b1;
          m_own_wr_ff[m] <= 1'b1;
          m_we_ff[m] <= 1'b1;
          m_addr_ff[m] <= dst_addr_ff;
          m_wdata_ff[m] <= fif.pop_data;
        end else if (rd_on_port[m]) begin
          m_busy_ff[m] <= 1'b1;
          m_own_wr_ff[m] <= 1'b0;
          m_we_ff[m] <= 1'b0;
          m_addr_ff[m] <= src_addr_ff;
        end else if (m_fin[m]) begin
          m_busy_ff[m] <= 1'b0;
          m_we_ff[m] <= 1'b0;
        end
      end
    end
  end
endmodule : mdc_top

//--- verif/mdc_checker.sv
module mdc_checker import mdc_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ch_start_i,
  input wire logic [MDC_LEN_W-1:0] block_len_i,
  input wire logic irq_clear_i,
  input wire logic [MDC_MASTERS-1:0] m_done_i,
  input wire logic [MDC_MASTERS-1:0] m_req_o,
  input wire logic [MDC_HS_NUM-1:0] src_ack_o,
  input wire logic [MDC_HS_NUM-1:0] dst_ack_o,
  input wire logic ch_active_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_go;
    !ch_active_o && ch_start_i && block_len_i != 12'h000;
  endsequence
  sequence s_sack;
    src_ack_o != 11'h000;
  endsequence
  property p_start; s_go |=> ch_active_o; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_zero; !ch_active_o && ch_start_i && block_len_i == 12'h000 |=> !ch_active_o; endproperty
  a_zero: assert property (p_zero) else $error("empty block started");
  property p_hold0; m_req_o[0] && !m_done_i[0] |=> m_req_o[0]; endproperty
  a_hold0: assert property (p_hold0) else $error("port 0 access dropped early");
  property p_gap1; m_req_o[1] && m_done_i[1] |=> !m_req_o[1]; endproperty
  a_gap1: assert property (p_gap1) else $error("port 1 no gap after done");
  property p_idle; !ch_active_o |-> m_req_o == 2'h0; endproperty
  a_idle: assert property (p_idle) else $error("access while channel off");
  property p_end; $fell(ch_active_o) |-> irq_o; endproperty
  a_end: assert property (p_end) else $error("block end without irq");
  property p_sticky; irq_o && !irq_clear_i |=> irq_o; endproperty
  a_sticky: assert property (p_sticky) else $error("irq lost");
  property p_clear; irq_clear_i && !ch_active_o |=> !irq_o; endproperty
  a_clear: assert property (p_clear) else $error("irq not cleared");
  property p_ack; s_sack |-> $onehot(src_ack_o) ##1 (src_ack_o == 11'h000); endproperty
  a_ack: assert property (p_ack) else $error("source ack not one pulse");
  property p_dack; $onehot0(dst_ack_o); endproperty
  a_dack: assert property (p_dack) else $error("several dest acks");
endmodule : mdc_checker

bind mdc_top mdc_checker u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ch_start_i(ch_start_i),
  .block_len_i(block_len_i), .irq_clear_i(irq_clear_i), .m_done_i(m_done_i), .m_req_o(m_req_o),
  .src_ack_o(src_ack_o), .dst_ack_o(dst_ack_o), .ch_active_o(ch_active_o), .irq_o(irq_o));

//--- verif/mdc_bus_model.sv
module mdc_bus_model import mdc_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] wait_i,
  input wire logic [MDC_MASTERS-1:0] m_req_i,
  input wire logic [MDC_MASTERS-1:0][MDC_ADDR_W-1:0] m_addr_i,
  output logic [MDC_MASTERS-1:0] m_done_o,
  output logic [MDC_MASTERS-1:0][MDC_DATA_W-1:0] m_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff [MDC_MASTERS];
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      m_done_o <= 2'h0;
      m_rdata_o <= 64'h0;
      cnt_ff <= '{default: 4'h0};
    end else begin
      for (int p = 0; p < MDC_MASTERS; p++) begin
        if (m_req_i[p] && !m_done_o[p]) begin
          cnt_ff[p] <= cnt_ff[p] + 4'h1;
          m_done_o[p] <= (cnt_ff[p] >= wait_i);
          m_rdata_o[p] <= {~m_addr_i[p][15:0], m_addr_i[p][15:0]};
        end else begin
          cnt_ff[p] <= 4'h0;
          m_done_o[p] <= 1'b0;
          // idle bus inverts the last word every cycle
          m_rdata_o[p] <= ~m_rdata_o[p];
        end
      end
    end
  end
endmodule : mdc_bus_model

//--- verif/tb_multi_master_dma_controller.sv
module tb_multi_master_dma_controller import mdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ch_start = 1'b0;
  logic sw_sreq = 1'b0;
  logic sw_dreq = 1'b0;
  logic sw_sing = 1'b1;
  logic irq_clr = 1'b0;
  logic [MDC_LEN_W-1:0] block_len = 12'h000;
  logic [MDC_ADDR_W-1:0] sa = 32'h0000_1000;
  logic [MDC_ADDR_W-1:0] da = 32'h0000_8000;
  logic sinc, dinc, sl, dl, fifo, smem, dmem, act, irq;
  mdc_hs_mode_type smode, dmode;
  logic [MDC_HS_SEL_W-1:0] ssel, dsel;
  logic [MDC_HS_NUM-1:0] hs_req, hs_sing, sack, dack, last_sack, last_dack;
  logic [3:0] wt;
  logic [MDC_MASTERS-1:0] m_done, m_req, m_we;
  logic [MDC_MASTERS-1:0][MDC_DATA_W-1:0] m_rdata, m_wdata;
  logic [MDC_MASTERS-1:0][MDC_ADDR_W-1:0] m_addr;
  logic [31:0] wa[$], wd[$];
  logic wp[$];
  int n_errors = 0, comparisons = 0, n_rd = 0, n_sack = 0, n_dack = 0, cyc = 0;

  mdc_top dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .ch_start_i(ch_start), .block_len_i(block_len),
    .src_addr_i(sa), .dst_addr_i(da), .src_inc_i(sinc), .dst_inc_i(dinc), .src_layer_i(sl), .dst_layer_i(dl),
    .fifo_mode_i(fifo), .src_is_mem_i(smem), .dst_is_mem_i(dmem), .src_mode_i(smode), .dst_mode_i(dmode),
    .src_sel_i(ssel), .dst_sel_i(dsel), .sw_src_req_i(sw_sreq), .sw_src_single_i(sw_sing),
    .sw_dst_req_i(sw_dreq), .sw_dst_single_i(sw_sing), .hs_req_i(hs_req), .hs_single_i(hs_sing),
    .irq_clear_i(irq_clr), .m_done_i(m_done), .m_rdata_i(m_rdata), .m_req_o(m_req), .m_we_o(m_we),
    .m_addr_o(m_addr), .m_wdata_o(m_wdata), .src_ack_o(sack), .dst_ack_o(dack), .ch_active_o(act), .irq_o(irq));
  mdc_bus_model u_bus (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .wait_i(wt), .m_req_i(m_req),
    .m_addr_i(m_addr), .m_done_o(m_done), .m_rdata_o(m_rdata));

  always #5 sys_clk = ~sys_clk;

  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // longest block needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (sack != 11'h000) begin
      n_sack++;
      last_sack = sack;
    end
    if (dack != 11'h000) begin
      n_dack++;
      last_dack = dack;
    end
    for (int p = 0; p < MDC_MASTERS; p++) begin
      if (m_req[p] && m_done[p] && m_we[p]) begin
        wa.push_back(m_addr[p]);
        wd.push_back(m_wdata[p]);
        wp.push_back(p[0]);
      end else if (m_req[p] && m_done[p] && p[0] == sl) begin
        n_rd++;
      end
    end
    if (cyc == 8000) begin
      n_errors++;
      $display("mismatch t=%0t timeout", $time);
      results();
    end
  end

  task automatic dflt();
    sinc = 1'b1;
    dinc = 1'b1;
    sl = 1'b0;
    dl = 1'b1;
    fifo = 1'b0;
    smem = 1'b1;
    dmem = 1'b1;
    smode = MDC_HS_HW;
    dmode = MDC_HS_HW;
    ssel = 4'h0;
    dsel = 4'h0;
    hs_req = 11'h000;
    hs_sing = 11'h000;
    wt = 4'h0;
    sw_sing = 1'b1;
  endtask : dflt

  task automatic start(input logic [MDC_LEN_W-1:0] len);
    wa.delete();
    wd.delete();
    wp.delete();
    n_rd = 0;
    n_sack = 0;
    n_dack = 0;
    @(negedge sys_clk);
    ch_start = 1'b1;
    block_len = len;
    @(negedge sys_clk);
    ch_start = 1'b0;
  endtask : start

  task automatic finish_blk(input int len);
    int i;
    logic [31:0] a;
    i = 0;
    while (act === 1'b1 && i < 3000) begin
      @(negedge sys_clk);
      i++;
    end
    chk(act, 1'b0);
    chk(wa.size(), len);
    chk(n_rd, len);
    chk(irq, 1'b1);
    for (i = 0; i < len; i++) begin
      a = sa + (sinc ? 32'h4 * i : 32'h0);
      chk(wd[i], {~a[15:0], a[15:0]});
      chk(wa[i], da + (dinc ? 32'h4 * i : 32'h0));
      chk(wp[i], dl);
    end
    irq_clr = 1'b1;
    @(negedge sys_clk);
    irq_clr = 1'b0;
    chk(irq, 1'b0);
  endtask : finish_blk

  task automatic t_reset();
    chk(m_req, 2'h0);
    chk(act, 1'b0);
    chk(irq, 1'b0);
  endtask : t_reset

  task automatic t_mem2mem();
    start(12'h003);
    finish_blk(3);
    chk(n_sack, 0);
  endtask : t_mem2mem

  task automatic t_one_layer();
    dl = 1'b0;
    sinc = 1'b0;
    fifo = 1'b1;
    wt = 4'hF;
    start(12'h002);
    finish_blk(2);
  endtask : t_one_layer

  task automatic t_zero();
    start(12'h000);
    repeat (2) @(negedge sys_clk);
    chk(act, 1'b0);
  endtask : t_zero

  task automatic t_hw_single();
    smem = 1'b0;
    ssel = 4'hA;
    hs_sing = 11'h400;
    hs_req = 11'h400;
    start(12'h002);
    finish_blk(2);
    chk(n_sack, 2);
    chk(last_sack, 11'h400);
  endtask : t_hw_single

  task automatic t_hw_burst();
    smem = 1'b0;
    ssel = 4'h3;
    hs_req = 11'h008;
    start(12'h006);
    finish_blk(6);
    chk(n_sack, 2);
  endtask : t_hw_burst

  task automatic t_irq_mode();
    smem = 1'b0;
    smode = MDC_HS_IRQ;
    ssel = 4'h5;
    hs_req = 11'h7DF;
    start(12'h001);
    repeat (20) @(negedge sys_clk);
    chk(n_rd, 0);
    hs_req = 11'h020;
    finish_blk(1);
    chk(last_sack, 11'h020);
  endtask : t_irq_mode

  task automatic t_sw();
    smem = 1'b0;
    smode = MDC_HS_SW;
    hs_req = 11'h7FF;
    start(12'h001);
    repeat (20) @(negedge sys_clk);
    chk(n_rd, 0);
    sw_sreq = 1'b1;
    @(negedge sys_clk);
    sw_sreq = 1'b0;
    finish_blk(1);
    chk(n_sack, 0);
  endtask : t_sw

  task automatic t_dst_stall();
    dmem = 1'b0;
    hs_sing = 11'h001;
    start(12'h003);
    repeat (30) @(negedge sys_clk);
    chk(n_rd, MDC_FIFO_DEPTH);
    hs_req = 11'h001;
    finish_blk(3);
    // last ack trails the block end by two edges
    repeat (2) @(negedge sys_clk);
    chk(n_dack, 3);
    chk(last_dack, 11'h001);
  endtask : t_dst_stall

  task automatic t_sw_dst();
    sl = 1'b1;
    dl = 1'b0;
    dmem = 1'b0;
    dmode = MDC_HS_SW;
    sw_sing = 1'b0;
    start(12'h002);
    repeat (20) @(negedge sys_clk);
    chk(wa.size(), 0);
    sw_dreq = 1'b1;
    @(negedge sys_clk);
    sw_dreq = 1'b0;
    finish_blk(2);
    chk(n_dack, 0);
  endtask : t_sw_dst

  initial begin
    dflt();
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_mem2mem();
    dflt();
    t_one_layer();
    dflt();
    t_zero();
    t_hw_single();
    dflt();
    t_hw_burst();
    dflt();
    t_irq_mode();
    dflt();
    t_sw();
    dflt();
    t_dst_stall();
    dflt();
    t_sw_dst();
    chk(m_req, 2'h0);
    results();
  end
endmodule : tb_multi_master_dma_controller
